// file: dwm_regs.svh
// Register offsets, reset values and counts of the dual watchdog monitor.
// Summary of operation
// - Host watchdog times programmed increments; host read-only.
// - Host watchdog time zero disables it entirely.
// - Every host interface access restarts host watchdog.
// - One shared process watchdog with own time.
// - Only trigger-enabled channel writes restart process watchdog.
// - Status bit0 low when expired; upper bits zero.
// - Reading process status clears its event request.
// - Host watchdog status goes to link status bit.
// - Host expiry counter increments, saturates at FFh.
// - Network write to either counter clears both.
// - Increment lasts divider value plus two clock cycles.
`ifndef DWM_REGS_SVH
`define DWM_REGS_SVH

`define DWM_OFS_DIV_LO   16'h0400
`define DWM_OFS_DIV_HI   16'h0401
`define DWM_OFS_HTIME_LO 16'h0410
`define DWM_OFS_HTIME_HI 16'h0411
`define DWM_OFS_PTIME_LO 16'h0420
`define DWM_OFS_PTIME_HI 16'h0421
`define DWM_OFS_STAT_LO  16'h0440
`define DWM_OFS_STAT_HI  16'h0441
`define DWM_OFS_PCNT     16'h0442
`define DWM_OFS_HCNT     16'h0443

`define DWM_RST_DIV      16'h09c2
`define DWM_RST_TIME     16'h03e8
`define DWM_RST_CNT      8'h00
`define DWM_TIME_OFF     16'h0000
`define DWM_CNT_MAX      8'hff
`define DWM_DIV_EXTRA    16'h0002
`define DWM_STAT_BIT     0

`endif

// file: dwm_pkg.sv
// Types shared by the dual watchdog monitor files.
package dwm_pkg;

  typedef enum logic [1:0] {
    DWM_WD_RUN = 2'b01,
    DWM_WD_EXP = 2'b10
  } dwm_wd_state_t;

  typedef struct packed {
    logic [15:0] addr;
    logic        wr;
    logic        rd;
    logic [7:0]  wdata;
  } dwm_bus_req_t;

endpackage

// file: dwm_tick.sv
// Basic watchdog increment divider.
`timescale 1ns/1ps
`default_nettype none
`include "dwm_regs.svh"
module dwm_tick #(
  parameter int DIV_W = 16
) (
  input  wire logic             clk_sys,
  input  wire logic             rst_n,
  input  wire logic [DIV_W-1:0] div_value,
  output logic                  tick
);

  logic [DIV_W-1:0] cnt_reg;
  logic [DIV_W-1:0] cnt_next;
  logic             tick_reg;
  logic             tick_next;
  logic [DIV_W-1:0] last;

  always_comb begin
    last      = DIV_W'(div_value + DIV_W'(`DWM_DIV_EXTRA) - DIV_W'(1));
    tick_next = (cnt_reg >= last);
    cnt_next  = tick_next ? '0 : DIV_W'(cnt_reg + DIV_W'(1));
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      cnt_reg  <= '0;
      tick_reg <= 1'b0;
    end else begin
      cnt_reg  <= cnt_next;
      tick_reg <= tick_next;
    end
  end

  assign tick = tick_reg;

  logic [DIV_W-1:0] gap_reg;
  logic             seen_reg;
  logic [DIV_W-1:0] div_q_reg;
  logic             chg_reg;

  // A divider change spoils only the period in which it falls, so that period is not judged.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      gap_reg   <= '0;
      seen_reg  <= 1'b0;
      div_q_reg <= '0;
      chg_reg   <= 1'b0;
    end else begin
      gap_reg   <= tick_reg ? DIV_W'(1) : DIV_W'(gap_reg + DIV_W'(1));
      seen_reg  <= seen_reg | tick_reg;
      div_q_reg <= div_value;
      chg_reg   <= tick_reg ? 1'b0 : (chg_reg | (div_value != div_q_reg));
    end
  end

  AST_TICK_PERIOD: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (tick_reg && seen_reg && !chg_reg && div_value == div_q_reg)
    |-> gap_reg == DIV_W'(div_value + DIV_W'(`DWM_DIV_EXTRA)))
    else $error("Watchdog increment period wrong.");

endmodule
`default_nettype wire

// file: dwm_top.sv
// Dual watchdog monitor: host interface and process data watchdogs.
`timescale 1ns/1ps
`default_nettype none
`include "dwm_regs.svh"
module dwm_top (
  input  wire logic                 clk_sys,
  input  wire logic                 rst_n,
  input  wire dwm_pkg::dwm_bus_req_t net_req,
  output logic [7:0]                net_rdata,
  input  wire dwm_pkg::dwm_bus_req_t host_req,
  output logic [7:0]                host_rdata,
  input  wire logic                 chan_write,
  input  wire logic                 chan_trigger_en,
  output logic                      link_status_host_wd_ok,
  output logic                      event_request_process_wd
);

  localparam int HOST = 0;
  localparam int PROC = 1;

  logic [15:0]           div_reg,   div_next;
  logic [15:0]           time_reg   [2];
  logic [15:0]           time_next  [2];
  logic [15:0]           cnt_reg    [2];
  logic [15:0]           cnt_next   [2];
  dwm_pkg::dwm_wd_state_t state_reg [2];
  dwm_pkg::dwm_wd_state_t state_next[2];
  logic [7:0]            exp_reg    [2];
  logic [7:0]            exp_next   [2];
  logic                  event_reg, event_next;
  logic                  hok_reg,   hok_next;
  logic [7:0]            nrd_reg,   nrd_next;
  logic [7:0]            hrd_reg,   hrd_next;
  logic [1:0]            restart;
  logic [1:0]            expire;
  logic                  tick;
  logic                  cnt_clear;
  logic                  stat_read;

  dwm_tick #(
    .DIV_W(16)
  ) u_tick (
    .clk_sys  (clk_sys),
    .rst_n    (rst_n),
    .div_value(div_reg),
    .tick     (tick)
  );

  function automatic logic [7:0] rd_byte(input logic [15:0] a);
    logic [7:0] v;
    v = 8'h00;
    unique case (a)
      `DWM_OFS_DIV_LO:   v = div_reg[7:0];
      `DWM_OFS_DIV_HI:   v = div_reg[15:8];
      `DWM_OFS_HTIME_LO: v = time_reg[HOST][7:0];
      `DWM_OFS_HTIME_HI: v = time_reg[HOST][15:8];
      `DWM_OFS_PTIME_LO: v = time_reg[PROC][7:0];
      `DWM_OFS_PTIME_HI: v = time_reg[PROC][15:8];
      `DWM_OFS_STAT_LO:  v = {7'h00, state_reg[PROC] != dwm_pkg::DWM_WD_EXP};
      `DWM_OFS_PCNT:     v = exp_reg[PROC];
      `DWM_OFS_HCNT:     v = exp_reg[HOST];
      default:           v = 8'h00;
    endcase
    return v;
  endfunction

  always_comb begin
    restart[HOST] = host_req.rd | host_req.wr;
    restart[PROC] = chan_write & chan_trigger_en;
    cnt_clear     = net_req.wr &&
                    (net_req.addr == `DWM_OFS_PCNT || net_req.addr == `DWM_OFS_HCNT);
    stat_read     = (net_req.rd && net_req.addr == `DWM_OFS_STAT_LO) ||
                    (host_req.rd && host_req.addr == `DWM_OFS_STAT_LO);
    div_next      = div_reg;
    time_next[HOST] = time_reg[HOST];
    time_next[PROC] = time_reg[PROC];
    // Only the network side may change timing; host writes are dropped.
    if (net_req.wr) begin
      unique case (net_req.addr)
        `DWM_OFS_DIV_LO:   div_next[7:0]          = net_req.wdata;
        `DWM_OFS_DIV_HI:   div_next[15:8]         = net_req.wdata;
        `DWM_OFS_HTIME_LO: time_next[HOST][7:0]   = net_req.wdata;
        `DWM_OFS_HTIME_HI: time_next[HOST][15:8]  = net_req.wdata;
        `DWM_OFS_PTIME_LO: time_next[PROC][7:0]   = net_req.wdata;
        `DWM_OFS_PTIME_HI: time_next[PROC][15:8]  = net_req.wdata;
        default:           div_next               = div_reg;
      endcase
    end
    nrd_next = net_req.rd ? rd_byte(net_req.addr) : nrd_reg;
    hrd_next = host_req.rd ? rd_byte(host_req.addr) : hrd_reg;
  end

  always_comb begin
    for (int i = 0; i < 2; i++) begin
      state_next[i] = state_reg[i];
      cnt_next[i]   = cnt_reg[i];
      expire[i]     = 1'b0;
      if (time_reg[i] == `DWM_TIME_OFF) begin
        state_next[i] = dwm_pkg::DWM_WD_RUN;
        cnt_next[i]   = 16'h0000;
      end else if (restart[i]) begin
        state_next[i] = dwm_pkg::DWM_WD_RUN;
        cnt_next[i]   = 16'h0000;
      end else if (state_reg[i] == dwm_pkg::DWM_WD_RUN && tick) begin
        if (16'(cnt_reg[i] + 16'h0001) >= time_reg[i]) begin
          state_next[i] = dwm_pkg::DWM_WD_EXP;
          expire[i]     = 1'b1;
        end else begin
          cnt_next[i] = 16'(cnt_reg[i] + 16'h0001);
        end
      end
      // A clear and an expiry in one cycle leave a count of one.
      exp_next[i] = cnt_clear ? `DWM_RST_CNT : exp_reg[i];
      if (expire[i] && exp_next[i] != `DWM_CNT_MAX) begin
        exp_next[i] = 8'(exp_next[i] + 8'h01);
      end
    end
    event_next = (event_reg & ~stat_read) | expire[PROC];
    hok_next   = state_next[HOST] != dwm_pkg::DWM_WD_EXP;
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      div_reg   <= `DWM_RST_DIV;
      event_reg <= 1'b0;
      hok_reg   <= 1'b1;
      nrd_reg   <= 8'h00;
      hrd_reg   <= 8'h00;
      for (int i = 0; i < 2; i++) begin
        time_reg[i]  <= `DWM_RST_TIME;
        cnt_reg[i]   <= 16'h0000;
        state_reg[i] <= dwm_pkg::DWM_WD_RUN;
        exp_reg[i]   <= `DWM_RST_CNT;
      end
    end else begin
      div_reg   <= div_next;
      event_reg <= event_next;
      hok_reg   <= hok_next;
      nrd_reg   <= nrd_next;
      hrd_reg   <= hrd_next;
      for (int i = 0; i < 2; i++) begin
        time_reg[i]  <= time_next[i];
        cnt_reg[i]   <= cnt_next[i];
        state_reg[i] <= state_next[i];
        exp_reg[i]   <= exp_next[i];
      end
    end
  end

  assign net_rdata                = nrd_reg;
  assign host_rdata               = hrd_reg;
  assign link_status_host_wd_ok   = hok_reg;
  assign event_request_process_wd = event_reg;

  default clocking dwm_cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  sequence s_host_time_write;
    host_req.wr && !net_req.wr &&
      (host_req.addr == `DWM_OFS_HTIME_LO || host_req.addr == `DWM_OFS_HTIME_HI);
  endsequence

  sequence s_status_read;
    net_req.rd && net_req.addr == `DWM_OFS_STAT_LO;
  endsequence

  AST_HOST_TIME_RO: assert property (s_host_time_write |=> $stable(time_reg[HOST]))
    else $error("Host side changed host watchdog time.");

  AST_DISABLED: assert property ((time_reg[HOST] == `DWM_TIME_OFF) [*2]
    |-> hok_reg && state_reg[HOST] == dwm_pkg::DWM_WD_RUN)
    else $error("Disabled host watchdog reports expiry.");

  AST_HOST_RESTART: assert property ((host_req.rd || host_req.wr)
    |=> cnt_reg[HOST] == 16'h0000 && state_reg[HOST] == dwm_pkg::DWM_WD_RUN && hok_reg)
    else $error("Host access did not restart host watchdog.");

  AST_PD_RESTART: assert property ((chan_write && chan_trigger_en)
    |=> cnt_reg[PROC] == 16'h0000 && state_reg[PROC] == dwm_pkg::DWM_WD_RUN)
    else $error("Triggered channel write did not restart process watchdog.");

  AST_PD_NO_RESTART: assert property ((chan_write && !chan_trigger_en && !tick
    && time_reg[PROC] != `DWM_TIME_OFF) |=> $stable(cnt_reg[PROC]))
    else $error("Untriggered channel write restarted process watchdog.");

  AST_STATUS_BIT: assert property (s_status_read
    |=> net_rdata == {7'h00, $past(state_reg[PROC]) != dwm_pkg::DWM_WD_EXP})
    else $error("Process watchdog status read wrong.");

  AST_EVENT_CLEAR: assert property ((s_status_read and !expire[PROC])
    |=> !event_request_process_wd)
    else $error("Status read did not clear event request.");

  AST_EVENT_SET: assert property (expire[PROC] |=> event_request_process_wd [*1]
    ##0 state_reg[PROC] == dwm_pkg::DWM_WD_EXP)
    else $error("Process expiry did not raise event request.");

  AST_PCNT_SAT: assert property ((exp_reg[PROC] == `DWM_CNT_MAX && !cnt_clear)
    |=> exp_reg[PROC] == `DWM_CNT_MAX)
    else $error("Process expiry counter left saturation.");

  AST_HCNT_INC: assert property ((expire[HOST] && !cnt_clear
    && exp_reg[HOST] != `DWM_CNT_MAX) |=> exp_reg[HOST] == 8'($past(exp_reg[HOST]) + 8'h01))
    else $error("Host expiry counter did not count.");

  AST_CNT_CLEAR: assert property ((cnt_clear && expire == 2'b00)
    |=> exp_reg[HOST] == 8'h00 && exp_reg[PROC] == 8'h00)
    else $error("Counter write did not clear both counters.");

  AST_EXP_HOLD: assert property ((state_reg[PROC] == dwm_pkg::DWM_WD_EXP && !restart[PROC]
    && time_reg[PROC] != `DWM_TIME_OFF) |=> state_reg[PROC] == dwm_pkg::DWM_WD_EXP)
    else $error("Expired process watchdog did not hold.");

endmodule
`default_nettype wire

// file: dwm_chan_model.sv
// Model of the buffer channel units whose writes feed the process watchdog.
`timescale 1ns/1ps
`default_nettype none
module dwm_chan_model (
  input  wire logic clk_sys,
  output logic      chan_write,
  output logic      chan_trigger_en
);
  initial begin
    chan_write      = 1'b0;
    chan_trigger_en = 1'b1;
  end

  // One channel write; the qualifier is left inverted afterwards so a stale level never helps.
  task automatic put(input logic trig);
    @(posedge clk_sys);
    #1;
    chan_write      = 1'b1;
    chan_trigger_en = trig;
    @(posedge clk_sys);
    #1;
    chan_write      = 1'b0;
    chan_trigger_en = ~trig;
  endtask
endmodule
`default_nettype wire

// file: tb_dual_watchdog_monitor.sv
// Self-checking testbench of the dual watchdog monitor.
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) \
  begin \
    samples_checked++; \
    if ((g) !== (e)) begin \
      num_errors++; \
      $display("Error at %0t: got %h expected %h", $time, (g), (e)); \
    end \
  end
module tb_dual_watchdog_monitor;
  logic                  clk_sys;
  logic                  rst_n;
  dwm_pkg::dwm_bus_req_t net_req;
  dwm_pkg::dwm_bus_req_t host_req;
  logic [7:0]            net_rdata;
  logic [7:0]            host_rdata;
  logic                  chan_write;
  logic                  chan_trigger_en;
  logic                  link_status_host_wd_ok;
  logic                  event_request_process_wd;
  logic [7:0]            q;
  int                    num_errors;
  int                    samples_checked;

  dwm_top dwm_top_i (
    .clk_sys                  (clk_sys),
    .rst_n                    (rst_n),
    .net_req                  (net_req),
    .net_rdata                (net_rdata),
    .host_req                 (host_req),
    .host_rdata               (host_rdata),
    .chan_write               (chan_write),
    .chan_trigger_en          (chan_trigger_en),
    .link_status_host_wd_ok   (link_status_host_wd_ok),
    .event_request_process_wd (event_request_process_wd)
  );

  dwm_chan_model dwm_chan_model_i (
    .clk_sys         (clk_sys),
    .chan_write      (chan_write),
    .chan_trigger_en (chan_trigger_en)
  );

  initial clk_sys = 1'b0;
  always #20 clk_sys = ~clk_sys;

  task automatic test_done();
    if (num_errors == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic wt(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask

  // One byte access on either side; a read result is taken after its answering edge.
  task automatic acc(input logic h, input logic w, input logic [15:0] a, input logic [7:0] d);
    dwm_pkg::dwm_bus_req_t r;
    r = '{a, w, ~w, d};
    @(posedge clk_sys);
    #1;
    if (h) host_req = r;
    else net_req = r;
    @(posedge clk_sys);
    #1;
    host_req = '0;
    net_req  = '0;
    q = h ? host_rdata : net_rdata;
  endtask

  task automatic nw(input logic [15:0] a, input logic [7:0] d);
    acc(1'b0, 1'b1, a, d);
  endtask

  task automatic rdchk(input logic h, input logic [15:0] a, input logic [7:0] e);
    acc(h, 1'b0, a, 8'h00);
    `CHK(q, e)
  endtask

  task automatic t_reset();
    logic [15:0] a [6];
    logic [7:0]  e [6];
    a = '{16'h0400, 16'h0401, 16'h0410, 16'h0411, 16'h0420, 16'h0421};
    e = '{8'hc2, 8'h09, 8'he8, 8'h03, 8'he8, 8'h03};
    `CHK(link_status_host_wd_ok, 1'b1)
    `CHK(event_request_process_wd, 1'b0)
    foreach (a[i]) rdchk(1'b0, a[i], e[i]);
    rdchk(1'b1, 16'h0411, 8'h03);
    rdchk(1'b0, 16'h0443, 8'h00);
  endtask

  task automatic t_proc();
    nw(16'h0420, 8'h02);
    nw(16'h0421, 8'h00);
    dwm_chan_model_i.put(1'b1);
    acc(1'b0, 1'b0, 16'h0440, 8'h00);
    dwm_chan_model_i.put(1'b1);
    nw(16'h0442, 8'h00);
    repeat (6) begin
      dwm_chan_model_i.put(1'b1);
      wt(1);
    end
    `CHK(event_request_process_wd, 1'b0)
    repeat (4) begin
      dwm_chan_model_i.put(1'b0);
      wt(1);
    end
    wt(2);
    `CHK(event_request_process_wd, 1'b1)
    rdchk(1'b0, 16'h0440, 8'h00);
    `CHK(event_request_process_wd, 1'b0)
    rdchk(1'b0, 16'h0441, 8'h00);
    rdchk(1'b0, 16'h0442, 8'h01);
    dwm_chan_model_i.put(1'b1);
    rdchk(1'b0, 16'h0440, 8'h01);
  endtask

  task automatic t_host();
    nw(16'h0411, 8'h00);
    nw(16'h0410, 8'h02);
    acc(1'b1, 1'b0, 16'h0000, 8'h00);
    nw(16'h0443, 8'h00);
    repeat (8) acc(1'b1, 1'b0, 16'h0000, 8'h00);
    `CHK(link_status_host_wd_ok, 1'b1)
    wt(3);
    `CHK(link_status_host_wd_ok, 1'b1)
    wt(9);
    `CHK(link_status_host_wd_ok, 1'b0)
    rdchk(1'b0, 16'h0443, 8'h01);
    rdchk(1'b1, 16'h0443, 8'h01);
    `CHK(link_status_host_wd_ok, 1'b1)
    acc(1'b1, 1'b1, 16'h0442, 8'h5a);
    acc(1'b1, 1'b1, 16'h0410, 8'h07);
    rdchk(1'b0, 16'h0443, 8'h01);
    rdchk(1'b0, 16'h0410, 8'h02);
    nw(16'h0410, 8'h00);
    wt(30);
    `CHK(link_status_host_wd_ok, 1'b1)
  endtask

  // Drives both expiry counters past their ceiling, then clears them together.
  task automatic t_sat();
    nw(16'h0410, 8'h02);
    repeat (260) begin
      acc(1'b1, 1'b0, 16'h0000, 8'h00);
      dwm_chan_model_i.put(1'b1);
      wt(14);
    end
    rdchk(1'b0, 16'h0442, 8'hff);
    rdchk(1'b0, 16'h0443, 8'hff);
    nw(16'h0442, 8'h00);
    rdchk(1'b0, 16'h0442, 8'h00);
    rdchk(1'b0, 16'h0443, 8'h00);
  endtask

  initial begin
    net_req  = '0;
    host_req = '0;
    rst_n    = 1'b0;
    repeat (4) @(posedge clk_sys);
    #1;
    rst_n = 1'b1;
    t_reset();
    nw(16'h0400, 8'h03);
    nw(16'h0401, 8'h00);
    t_proc();
    t_host();
    t_sat();
    test_done();
  end

  initial begin
    #800000;
    num_errors++;
    test_done();
  end
endmodule
`default_nettype wire
